// >>> src/ch2c_regs.sv
// Channel-two configuration register bank on the device control port
//
// How it works
// - Five 8-bit registers on page zero at 0x41 through 0x45.
// - Input config bit 7 picks microphone (0) or line (1), reset 0.
// - Bits 6-5 pick differential, single-ended or PDM source; code 3 reserved.
// - Bit 4 picks AC or DC coupling, ignored for PDM source.
// - Bits 3-2 pick 2.5k, 10k or 20k input impedance; code 3 reserved.
// - Bit 0 enables range processing; external mode bit picks enhancer or level control.
// - Gain bits 7-2 set 0 to 42 dB in 1 dB steps, reset 0.
// - Volume code 0 mutes; 1 to 255 span -100 to 27 dB.
// - Volume register resets to c9, unity digital gain.
// - Trim bits 7-4 span -0.8 to 0.7 dB, reset 8.
// - Input config and gain registers both reset to zero.
// - Phase trim holds 0 to 255 modulator cycles of delay, reset zero.
`default_nettype none
module ch2c_regs
   import ch2c_pkg::*;
(
   input  wire logic       clock,
   input  wire logic       rst_n,
   input  wire logic       reg_write,
   input  wire logic       reg_read,
   input  wire logic [7:0] reg_page,
   input  wire logic [7:0] reg_addr,
   input  wire logic [7:0] reg_wdata,
   input  wire logic       range_mode_select,
   output var  logic [7:0] read_data_r,
   output var  logic       read_valid_r,
   output var  logic [7:0] input_config_r,
   output var  logic [7:0] analog_gain_r,
   output var  logic [7:0] digital_volume_r,
   output var  logic [7:0] gain_trim_r,
   output var  logic [7:0] phase_trim_r,
   output var  logic       analog_dc_coupled_r,
   output var  logic       enhancer_on_r,
   output var  logic       level_control_on_r,
   output var  logic       muted_r
);

   logic                    rst_meta_r;
   logic                    rst_sync_n;
   logic [REG_COUNT-1:0][7:0] regs_r;
   logic [REG_COUNT-1:0][7:0] regs_nxt;
   logic [7:0]              read_data_nxt;
   logic                    read_valid_nxt;
   logic                    analog_dc_nxt;
   logic                    enhancer_nxt;
   logic                    level_nxt;
   logic                    muted_nxt;
   logic [2:0]              wr_idx;
   logic [2:0]              rd_idx;
   logic [7:0]              rd_mux;
   ch2c_cfg_s               cfg;

   // Page and offset to register index, shared by write and read paths
   function automatic logic [2:0] reg_index(input logic [7:0] page, input logic [7:0] addr);
      logic [2:0] idx;
      idx = IDX_NONE;
      if (page == CFG_PAGE) begin
         case (addr)
            OFS_INPUT_CONFIG:   idx = IDX_INPUT_CONFIG;
            OFS_ANALOG_GAIN:    idx = IDX_ANALOG_GAIN;
            OFS_DIGITAL_VOLUME: idx = IDX_DIGITAL_VOLUME;
            OFS_GAIN_TRIM:      idx = IDX_GAIN_TRIM;
            OFS_PHASE_TRIM:     idx = IDX_PHASE_TRIM;
            default:            idx = IDX_NONE;
         endcase
      end
      return idx;
   endfunction

   // Reset release is synchronised; assertion stays asynchronous
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         rst_meta_r <= 1'b0;
         rst_sync_n <= 1'b0;
      end else begin
         rst_meta_r <= 1'b1;
         rst_sync_n <= rst_meta_r;
      end
   end

   assign wr_idx = reg_index(reg_page, reg_addr);
   assign rd_idx = reg_index(reg_page, reg_addr);

   always_comb begin
      regs_nxt = regs_r;
      for (int i = 0; i < REG_COUNT; i++) begin
         if (reg_write && wr_idx == 3'(i)) begin
            regs_nxt[i] = reg_wdata & REG_MASK[i];
         end
      end
   end

   // Unmapped reads answer zero rather than stale data
   always_comb begin
      rd_mux = 8'h00;
      if (rd_idx != IDX_NONE) begin
         rd_mux = regs_r[rd_idx] & REG_MASK[rd_idx];
      end
   end

   // Reserved bit 1 has no place in the field struct
   assign cfg = {regs_nxt[IDX_INPUT_CONFIG][POS_INPUT_KIND:POS_IMPEDANCE_LO],
                 regs_nxt[IDX_INPUT_CONFIG][POS_RANGE_ENABLE],
                 regs_nxt[IDX_ANALOG_GAIN][POS_GAIN_HI:POS_GAIN_LO],
                 regs_nxt[IDX_DIGITAL_VOLUME],
                 regs_nxt[IDX_GAIN_TRIM][POS_TRIM_HI:POS_TRIM_LO],
                 regs_nxt[IDX_PHASE_TRIM]};

   always_comb begin
      read_valid_nxt = reg_read;
      read_data_nxt  = reg_read ? rd_mux : read_data_r;
      // Coupling only reaches the analog front end
      analog_dc_nxt  = cfg.coupling_select
                       && (cfg.input_source_select != SRC_PDM_MIC);
      enhancer_nxt   = cfg.range_processing_enable && !range_mode_select;
      level_nxt      = cfg.range_processing_enable && range_mode_select;
      muted_nxt      = (cfg.digital_volume_field == VOLUME_MUTE_CODE);
   end

   always_ff @(posedge clock or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         regs_r              <= REG_RESET;
         read_data_r         <= 8'h00;
         read_valid_r        <= 1'b0;
         analog_dc_coupled_r <= 1'b0;
         enhancer_on_r       <= 1'b0;
         level_control_on_r  <= 1'b0;
         muted_r             <= 1'b0;
      end else begin
         regs_r              <= regs_nxt;
         read_data_r         <= read_data_nxt;
         read_valid_r        <= read_valid_nxt;
         analog_dc_coupled_r <= analog_dc_nxt;
         enhancer_on_r       <= enhancer_nxt;
         level_control_on_r  <= level_nxt;
         muted_r             <= muted_nxt;
      end
   end

   // Field outputs are the stored registers themselves, no extra latency
   assign input_config_r   = regs_r[IDX_INPUT_CONFIG];
   assign analog_gain_r    = regs_r[IDX_ANALOG_GAIN];
   assign digital_volume_r = regs_r[IDX_DIGITAL_VOLUME];
   assign gain_trim_r      = regs_r[IDX_GAIN_TRIM];
   assign phase_trim_r     = regs_r[IDX_PHASE_TRIM];

   sequence s_write(logic [7:0] ofs);
      reg_write && reg_page == CFG_PAGE && reg_addr == ofs;
   endsequence

   sequence s_read_mapped;
      reg_read && reg_page == CFG_PAGE
      && reg_addr >= OFS_INPUT_CONFIG && reg_addr <= OFS_PHASE_TRIM;
   endsequence

   sequence s_read(logic [7:0] ofs);
      reg_read && reg_page == CFG_PAGE && reg_addr == ofs;
   endsequence

   // Anything but a mapped write must leave the bank untouched
   sequence s_no_bank_write;
      !reg_write || reg_page != CFG_PAGE
      || reg_addr < OFS_INPUT_CONFIG || reg_addr > OFS_PHASE_TRIM;
   endsequence

   a_wr_input_cfg: assert property (@(posedge clock) disable iff (!rst_sync_n)
      s_write(OFS_INPUT_CONFIG) |=> input_config_r == ($past(reg_wdata) & 8'hfd))
      else $error("input config write not stored as masked");

   a_kind_bit: assert property (@(posedge clock) disable iff (!rst_sync_n)
      s_write(OFS_INPUT_CONFIG) |=> input_config_r[7] == $past(reg_wdata[7]))
      else $error("input kind bit wrong after write");

   a_source_field: assert property (@(posedge clock) disable iff (!rst_sync_n)
      s_write(OFS_INPUT_CONFIG) |=> input_config_r[6:5] == $past(reg_wdata[6:5]))
      else $error("source field wrong after write");

   a_coupling_gate: assert property (@(posedge clock) disable iff (!rst_sync_n)
      ##1 analog_dc_coupled_r == (input_config_r[4] && input_config_r[6:5] != 2'h2))
      else $error("coupling output not gated by source");

   a_impedance_fld: assert property (@(posedge clock) disable iff (!rst_sync_n)
      s_write(OFS_INPUT_CONFIG) |=> input_config_r[3:2] == $past(reg_wdata[3:2]))
      else $error("impedance field wrong after write");

   a_range_split: assert property (@(posedge clock) disable iff (!rst_sync_n)
      ##1 (enhancer_on_r == (input_config_r[0] && !$past(range_mode_select)))
      && (level_control_on_r == (input_config_r[0] && $past(range_mode_select))))
      else $error("range processing selection wrong");

   a_gain_write: assert property (@(posedge clock) disable iff (!rst_sync_n)
      s_write(OFS_ANALOG_GAIN) |=> analog_gain_r == {$past(reg_wdata[7:2]), 2'b00})
      else $error("gain register write wrong");

   a_volume_mute: assert property (@(posedge clock) disable iff (!rst_sync_n)
      s_write(OFS_DIGITAL_VOLUME) |=> muted_r == ($past(reg_wdata) == 8'h00))
      else $error("mute flag disagrees with volume");

   a_trim_write: assert property (@(posedge clock) disable iff (!rst_sync_n)
      s_write(OFS_GAIN_TRIM) |=> gain_trim_r == {$past(reg_wdata[7:4]), 4'h0})
      else $error("trim register write wrong");

   a_reset_values: assert property (@(posedge clock) disable iff (!rst_sync_n)
      $rose(rst_sync_n) |-> input_config_r == 8'h00 && analog_gain_r == 8'h00
      && digital_volume_r == 8'hc9 && gain_trim_r == 8'h80 && phase_trim_r == 8'h00)
      else $error("register reset values wrong");

   a_read_back: assert property (@(posedge clock) disable iff (!rst_sync_n)
      s_read_mapped |=> read_valid_r && read_data_r == $past(rd_mux))
      else $error("read data does not match register");

   a_unmapped_zero: assert property (@(posedge clock) disable iff (!rst_sync_n)
      reg_read && (reg_page != CFG_PAGE || reg_addr < OFS_INPUT_CONFIG
      || reg_addr > OFS_PHASE_TRIM) |=> read_valid_r && read_data_r == 8'h00)
      else $error("unmapped read not zero");

   a_coupling_bit: assert property (@(posedge clock) disable iff (!rst_sync_n)
      s_write(OFS_INPUT_CONFIG) |=> input_config_r[4] == $past(reg_wdata[4]))
      else $error("coupling bit wrong after write");

   a_range_bit: assert property (@(posedge clock) disable iff (!rst_sync_n)
      s_write(OFS_INPUT_CONFIG) |=> input_config_r[0] == $past(reg_wdata[0]))
      else $error("range enable bit wrong after write");

   a_reserved_bit_wr: assert property (@(posedge clock) disable iff (!rst_sync_n)
      s_write(OFS_INPUT_CONFIG) |=> input_config_r[1] == 1'b0)
      else $error("reserved config bit took a write");

   a_volume_write: assert property (@(posedge clock) disable iff (!rst_sync_n)
      s_write(OFS_DIGITAL_VOLUME) |=> digital_volume_r == $past(reg_wdata))
      else $error("volume register write wrong");

   a_phase_write: assert property (@(posedge clock) disable iff (!rst_sync_n)
      s_write(OFS_PHASE_TRIM) |=> phase_trim_r == $past(reg_wdata))
      else $error("phase trim register write wrong");

   a_read_config: assert property (@(posedge clock) disable iff (!rst_sync_n)
      s_read(OFS_INPUT_CONFIG) |=> read_valid_r && read_data_r == $past(input_config_r))
      else $error("input config read back wrong");

   a_read_gain: assert property (@(posedge clock) disable iff (!rst_sync_n)
      s_read(OFS_ANALOG_GAIN) |=> read_valid_r && read_data_r == $past(analog_gain_r))
      else $error("gain read back wrong");

   a_read_volume: assert property (@(posedge clock) disable iff (!rst_sync_n)
      s_read(OFS_DIGITAL_VOLUME) |=> read_valid_r && read_data_r == $past(digital_volume_r))
      else $error("volume read back wrong");

   a_read_trim: assert property (@(posedge clock) disable iff (!rst_sync_n)
      s_read(OFS_GAIN_TRIM) |=> read_valid_r && read_data_r == $past(gain_trim_r))
      else $error("trim read back wrong");

   a_read_phase: assert property (@(posedge clock) disable iff (!rst_sync_n)
      s_read(OFS_PHASE_TRIM) |=> read_valid_r && read_data_r == $past(phase_trim_r))
      else $error("phase trim read back wrong");

   a_valid_read: assert property (@(posedge clock) disable iff (!rst_sync_n)
      reg_read |=> read_valid_r)
      else $error("read not answered");

   a_valid_pulse: assert property (@(posedge clock) disable iff (!rst_sync_n)
      !reg_read |=> !read_valid_r)
      else $error("read valid without a read");

   a_read_hold: assert property (@(posedge clock) disable iff (!rst_sync_n)
      !reg_read |=> $stable(read_data_r))
      else $error("read data changed without a read");

   a_bank_hold: assert property (@(posedge clock) disable iff (!rst_sync_n)
      s_no_bank_write |=> $stable(input_config_r) && $stable(analog_gain_r)
      && $stable(digital_volume_r) && $stable(gain_trim_r) && $stable(phase_trim_r))
      else $error("register changed without a mapped write");

   a_reserved_zero: assert property (@(posedge clock) disable iff (!rst_sync_n)
      input_config_r[1] == 1'b0 && analog_gain_r[1:0] == 2'b00 && gain_trim_r[3:0] == 4'h0)
      else $error("reserved bits not zero");

   a_range_off: assert property (@(posedge clock) disable iff (!rst_sync_n)
      !input_config_r[0] |-> !enhancer_on_r && !level_control_on_r)
      else $error("range processing on while disabled");

   a_range_exclusive: assert property (@(posedge clock) disable iff (!rst_sync_n)
      !(enhancer_on_r && level_control_on_r))
      else $error("enhancer and level control both on");

   a_dc_pdm: assert property (@(posedge clock) disable iff (!rst_sync_n)
      input_config_r[6:5] == SRC_PDM_MIC |-> !analog_dc_coupled_r)
      else $error("dc coupling reported for pdm source");

   a_mute_level: assert property (@(posedge clock) disable iff (!rst_sync_n)
      muted_r == (digital_volume_r == VOLUME_MUTE_CODE))
      else $error("mute flag out of step with volume");

   a_reset_flags: assert property (@(posedge clock) disable iff (!rst_sync_n)
      $rose(rst_sync_n) |-> !read_valid_r && read_data_r == 8'h00 && !analog_dc_coupled_r
      && !enhancer_on_r && !level_control_on_r && !muted_r)
      else $error("status outputs wrong after reset");

endmodule
`default_nettype wire

// >>> include/ch2c_pkg.sv
// Constants and field layout of the channel-two configuration register bank
`default_nettype none
package ch2c_pkg;
   localparam int          REG_COUNT          = 5;
   localparam logic [7:0]  CFG_PAGE           = 8'h00;
   localparam logic [7:0]  OFS_INPUT_CONFIG   = 8'h41;
   localparam logic [7:0]  OFS_ANALOG_GAIN    = 8'h42;
   localparam logic [7:0]  OFS_DIGITAL_VOLUME = 8'h43;
   localparam logic [7:0]  OFS_GAIN_TRIM      = 8'h44;
   localparam logic [7:0]  OFS_PHASE_TRIM     = 8'h45;

   localparam logic [2:0]  IDX_INPUT_CONFIG   = 3'h0;
   localparam logic [2:0]  IDX_ANALOG_GAIN    = 3'h1;
   localparam logic [2:0]  IDX_DIGITAL_VOLUME = 3'h2;
   localparam logic [2:0]  IDX_GAIN_TRIM      = 3'h3;
   localparam logic [2:0]  IDX_PHASE_TRIM     = 3'h4;
   localparam logic [2:0]  IDX_NONE           = 3'h7;

   // Writable bits per register, index 0 in the low byte
   localparam logic [REG_COUNT-1:0][7:0] REG_MASK =
      {8'hff, 8'hf0, 8'hff, 8'hfc, 8'hfd};
   localparam logic [REG_COUNT-1:0][7:0] REG_RESET =
      {8'h00, 8'h80, 8'hc9, 8'h00, 8'h00};

   localparam int          POS_INPUT_KIND     = 7;
   localparam int          POS_SOURCE_HI      = 6;
   localparam int          POS_SOURCE_LO      = 5;
   localparam int          POS_COUPLING       = 4;
   localparam int          POS_IMPEDANCE_HI   = 3;
   localparam int          POS_IMPEDANCE_LO   = 2;
   localparam int          POS_RANGE_ENABLE   = 0;
   localparam int          POS_GAIN_HI        = 7;
   localparam int          POS_GAIN_LO        = 2;
   localparam int          POS_TRIM_HI        = 7;
   localparam int          POS_TRIM_LO        = 4;

   localparam logic [1:0]  SRC_ANALOG_DIFF    = 2'h0;
   localparam logic [1:0]  SRC_ANALOG_SINGLE  = 2'h1;
   localparam logic [1:0]  SRC_PDM_MIC        = 2'h2;
   localparam logic [7:0]  VOLUME_MUTE_CODE   = 8'h00;

   typedef struct packed {
      logic       input_kind_select;
      logic [1:0] input_source_select;
      logic       coupling_select;
      logic [1:0] input_impedance_select;
      logic       range_processing_enable;
      logic [5:0] channel_gain_field;
      logic [7:0] digital_volume_field;
      logic [3:0] gain_trim_field;
      logic [7:0] phase_trim_field;
   } ch2c_cfg_s;
endpackage
`default_nettype wire

// >>> dv/tb.sv
// Self-checking bench for the channel-two configuration register bank
`default_nettype none
module tb;
   timeunit 1ns;
   timeprecision 1ps;

   logic       clock             = 1'b0;
   logic       rst_n             = 1'b0;
   logic       reg_write         = 1'b0;
   logic       reg_read          = 1'b0;
   logic       range_mode_select = 1'b0;
   logic [7:0] reg_page          = 8'h00;
   logic [7:0] reg_addr          = 8'h00;
   logic [7:0] reg_wdata         = 8'h00;
   logic [7:0] read_data_r, input_config_r, analog_gain_r;
   logic [7:0] digital_volume_r, gain_trim_r, phase_trim_r;
   logic       read_valid_r, analog_dc_coupled_r, enhancer_on_r, level_control_on_r, muted_r;
   // Writable bits and reset image, index 0 is the input configuration register
   logic [7:0] mask    [5] = '{8'hfd, 8'hfc, 8'hff, 8'hf0, 8'hff};
   logic [7:0] rst_val [5] = '{8'h00, 8'h00, 8'hc9, 8'h80, 8'h00};
   logic [7:0] mdl     [5];
   logic [7:0] exp_q   [$];
   logic [7:0] off;
   logic       hit;
   logic       mode_s;
   logic       exp_valid;
   logic [7:0] last_rd    = 8'h00;
   logic [7:0] addr_v;
   bit         mon_on    = 1'b0;
   int         n_mismatch = 0;
   int         checks     = 0;
   int         seed       = 32'h103003d6;
   int         i;

   always #4 clock = ~clock;

   ch2c_regs dut_u (
      .clock(clock), .rst_n(rst_n), .reg_write(reg_write), .reg_read(reg_read),
      .reg_page(reg_page), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .range_mode_select(range_mode_select), .read_data_r(read_data_r),
      .read_valid_r(read_valid_r), .input_config_r(input_config_r),
      .analog_gain_r(analog_gain_r), .digital_volume_r(digital_volume_r),
      .gain_trim_r(gain_trim_r), .phase_trim_r(phase_trim_r),
      .analog_dc_coupled_r(analog_dc_coupled_r), .enhancer_on_r(enhancer_on_r),
      .level_control_on_r(level_control_on_r), .muted_r(muted_r));

   task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
      checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("MISMATCH %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic complete_run();
      $display("checks %0d n_mismatch %0d", checks, n_mismatch);
      if (n_mismatch == 0 && checks > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask

   task automatic op(input logic wr, rd, input logic [7:0] pg, ad, wd);
      @(posedge clock);
      reg_write <= wr;
      reg_read  <= rd;
      reg_page  <= pg;
      reg_addr  <= ad;
      reg_wdata <= wd;
   endtask

   // Reserved source, impedance and gain codes are steered to legal ones
   function automatic logic [7:0] legal(input logic [7:0] ad, input logic [7:0] wd);
      logic [7:0] v;
      v = wd;
      if (ad == 8'h41 && v[6:5] == 2'h3) v[6:5] = 2'h2;
      if (ad == 8'h41 && v[3:2] == 2'h3) v[3:2] = 2'h2;
      if (ad == 8'h42 && v[7:2] > 6'h2a) v[7:2] = v[7:2] - 6'h15;
      return v;
   endfunction

   // Reference model sees requests at the same edge the bank takes them
   always @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         for (int k = 0; k < 5; k++) mdl[k] = rst_val[k];
         mode_s = 1'b0;
         exp_valid = 1'b0;
      end else begin
         off = reg_addr - 8'h41;
         hit = (reg_page == 8'h00) && (reg_addr >= 8'h41) && (reg_addr <= 8'h45);
         mode_s = range_mode_select;
         exp_valid = reg_read;
         // Same-cycle read sees the old contents
         if (reg_read) exp_q.push_back(hit ? mdl[off] : 8'h00);
         if (reg_write && hit) mdl[off] = reg_wdata & mask[off];
      end
   end

   // Outputs settle by the falling edge
   always @(negedge clock) begin
      if (mon_on) begin
         check("read_valid", {7'h0, read_valid_r}, {7'h0, exp_valid});
         // Read data stands until the next read
         if (read_valid_r === 1'b1) last_rd = exp_q.size() ? exp_q.pop_front() : 8'hxx;
         check("read_data", read_data_r, last_rd);
         check("input_config", input_config_r, mdl[0]);
         check("analog_gain", analog_gain_r, mdl[1]);
         check("digital_volume", digital_volume_r, mdl[2]);
         check("gain_trim", gain_trim_r, mdl[3]);
         check("phase_trim", phase_trim_r, mdl[4]);
         check("dc_coupled", {7'h0, analog_dc_coupled_r},
               {7'h0, mdl[0][4] && (mdl[0][6:5] != 2'h2)});
         check("enhancer_on", {7'h0, enhancer_on_r}, {7'h0, mdl[0][0] && !mode_s});
         check("level_on", {7'h0, level_control_on_r}, {7'h0, mdl[0][0] && mode_s});
         check("muted", {7'h0, muted_r}, {7'h0, mdl[2] == 8'h00});
      end
   end

   initial begin
      #100000;
      n_mismatch++;
      $display("Watchdog expired before the sequence ended");
      complete_run();
   end

   initial begin
      repeat (2) @(posedge clock);
      mon_on = 1'b1;
      repeat (6) @(posedge clock);
      rst_n <= 1'b1;
      repeat (4) @(posedge clock);
      // Reset image plus both neighbours outside the bank
      for (i = 0; i < 7; i++) op(1'b0, 1'b1, 8'h00, 8'h40 + i[7:0], 8'h00);
      // Ones everywhere, read in the same cycle and again afterwards
      for (i = 0; i < 5; i++) op(1'b1, 1'b1, 8'h00, 8'h41 + i[7:0], 8'hff);
      for (i = 0; i < 5; i++) op(1'b0, 1'b1, 8'h00, 8'h41 + i[7:0], 8'h00);
      // Unmapped page and addresses must leave the bank alone
      op(1'b1, 1'b0, 8'h01, 8'h43, 8'h00);
      op(1'b1, 1'b0, 8'h00, 8'h46, 8'h00);
      op(1'b1, 1'b1, 8'h00, 8'h40, 8'h00);
      // Every legal source code against coupling and both range modes, with range enable set
      // Pin functions for each source are set up outside the bank
      for (i = 0; i < 16; i++) begin
         range_mode_select <= i[3];
         op(1'b1, 1'b1, 8'h00, 8'h41,
            legal(8'h41, {1'b0, i[1:0], i[2], 4'b0011}));
      end
      op(1'b1, 1'b0, 8'h00, 8'h42, 8'ha8);
      op(1'b1, 1'b0, 8'h00, 8'h43, 8'h00);
      op(1'b1, 1'b0, 8'h00, 8'h43, 8'h01);
      for (i = 0; i < 300; i++) begin
         addr_v = 8'h40 + 8'($random(seed) & 7);
         range_mode_select <= 1'($random(seed));
         op(1'($random(seed)), 1'($random(seed)), (($random(seed) & 3) == 0) ? 8'h01 : 8'h00,
            addr_v, legal(addr_v, 8'($random(seed))));
      end
      op(1'b0, 1'b0, 8'h00, 8'h00, 8'h00);
      repeat (4) @(posedge clock);
      check("pending_reads", 8'(exp_q.size()), 8'h00);
      complete_run();
   end
endmodule
`default_nettype wire
